// File: common/fdfe_map.svh
// sizes, encodings and reset values of the fetch/decode front end
`ifndef FDFE_MAP_SVH
`define FDFE_MAP_SVH
`define FDFE_BLK_BYTES    16
`define FDFE_BLK_END      5'h10
`define FDFE_BLK_STEP     32'h0000_0010
`define FDFE_ICACHE_BYTES 32768
`define FDFE_RESET_PC     32'h0000_0000
`define FDFE_PF_LINES     2
`define FDFE_BTB_ENTRIES  16
`define FDFE_BTB_CTR_INIT 2'h2
`define FDFE_LANES        8
`define FDFE_LANE_SLOT1   4
`define FDFE_LANE_SLOT2   6
`define FDFE_SLOT0_MAX    3'h4
`define FDFE_PACK_BASE    3'h4
`define FDFE_PACK_ENH     3'h2
`define FDFE_SP_PUSH      8'hFC
`define FDFE_SP_POP       8'h04
`define FDFE_CL_ALU       4'h0
`define FDFE_CL_LDOP      4'h1
`define FDFE_CL_STORE     4'h2
`define FDFE_CL_VSTORE    4'h3
`define FDFE_CL_PUSH      4'h4
`define FDFE_CL_POP       4'h5
`define FDFE_CL_CALL      4'h6
`define FDFE_CL_RET       4'h7
`define FDFE_CL_BRANCH    4'h8
`define FDFE_CL_VLOAD     4'h9
`define FDFE_CL_VSCAL     4'hA
`define FDFE_CL_VPACK     4'hB
`define FDFE_CL_VSHUF     4'hC
`define FDFE_CL_COMPLEX   4'hD
`endif

// File: common/fdfe_pkg.sv
// types shared by the fetch/decode front end
`include "fdfe_map.svh"
package fdfe_pkg;
   typedef logic [31:0] fdfe_addr_t;
   typedef enum logic [2:0] {
      UK_ALU = 3'h0,
      UK_LD  = 3'h1,
      UK_LDX = 3'h2,
      UK_ST  = 3'h3,
      UK_VEC = 3'h4,
      UK_BR  = 3'h5
   } fdfe_kind_e;
   typedef enum logic [3:0] {
      F_REQ  = 4'b0001,
      F_CHK  = 4'b0010,
      F_HOLD = 4'b0100,
      F_MISS = 4'b1000
   } fdfe_fst_e;
   typedef struct packed {
      logic       vld;
      fdfe_kind_e kind;
      logic [7:0] sp_ofs;
      logic [7:0] imm;
      fdfe_addr_t pc;
   } fdfe_uop_s;
   typedef struct packed {
      fdfe_uop_s [`FDFE_LANES-1:0] lane;
   } fdfe_issue_s;
   typedef struct packed {
      logic       vld;
      fdfe_addr_t pc;
   } fdfe_redir_s;
   typedef struct packed {
      logic       vld;
      logic       taken;
      fdfe_addr_t pc;
      fdfe_addr_t tgt;
   } fdfe_btb_upd_s;
   typedef struct packed {
      logic       vld;
      fdfe_addr_t addr;
   } fdfe_memreq_s;
   typedef struct packed {
      logic         ack;
      logic [127:0] data;
   } fdfe_memrsp_s;
   typedef struct packed {
      logic [2:0]            n;
      logic                  first_only;
      logic [7:0]            sp_chg;
      fdfe_kind_e [3:0]      k;
   } fdfe_dec_s;
endpackage : fdfe_pkg

// File: src/fdfe_front_end.sv
// fetch, branch prediction and three-way decode front end
`timescale 1ns/1ps
`include "fdfe_map.svh"
module fdfe_front_end #(
   parameter bit ENHANCED     = 1'b0,
   parameter int BTB_ENTRIES  = `FDFE_BTB_ENTRIES,
   parameter int PF_LINES     = `FDFE_PF_LINES,
   parameter int ICACHE_BYTES = `FDFE_ICACHE_BYTES
) (
   input  wire logic                   sys_clk_i,
   input  wire logic                   resetn_i,
   input  wire fdfe_pkg::fdfe_redir_s   redir_i,
   input  wire fdfe_pkg::fdfe_btb_upd_s btb_upd_i,
   input  wire fdfe_pkg::fdfe_memrsp_s  mem_rsp_i,
   output fdfe_pkg::fdfe_memreq_s       mem_req_o,
   input  wire logic                   issue_ready_i,
   output logic                        issue_valid_o,
   output fdfe_pkg::fdfe_issue_s        issue_o
);
   import fdfe_pkg::*;

   localparam int DEPTH = ICACHE_BYTES / `FDFE_BLK_BYTES;
   localparam int IDX_W = $clog2(DEPTH);
   localparam int TAG_W = 28 - IDX_W;
   localparam int BTB_W = $clog2(BTB_ENTRIES);
   localparam int CNT_W = $clog2(PF_LINES) + 1;

   fdfe_fst_e               st_q;
   fdfe_addr_t              fetch_pc_q;
   fdfe_addr_t              base_q;
   logic [127:0]            blk_q;
   logic [4:0]              off_q;
   logic [DEPTH-1:0]        vld_q;
   fdfe_memreq_s            mem_req_q;
   logic [CNT_W-1:0]        ref_cnt_q;
   logic                    issue_valid_q;
   fdfe_issue_s             issue_q;
   logic [7:0]              sp_q;
   logic                    btb_vld_q [BTB_ENTRIES];
   logic [1:0]              btb_ctr_q [BTB_ENTRIES];
   fdfe_addr_t              btb_tag_q [BTB_ENTRIES];
   fdfe_addr_t              btb_tgt_q [BTB_ENTRIES];

   logic                    cm_en;
   logic                    cm_we;
   logic [IDX_W-1:0]        cm_idx;
   logic [TAG_W+127:0]      cm_wdata;
   logic [TAG_W+127:0]      cm_rdata;
   logic                    hit;
   logic                    last_line;
   logic                    adv;
   logic [4:0]              pos [3];
   logic                    pres [3];
   logic [3:0]              cls [3];
   logic [7:0]              imm [3];
   fdfe_addr_t              spc [3];
   fdfe_dec_s               dec [3];
   logic                    pred [3];
   fdfe_addr_t              ptgt [3];
   logic                    take [3];
   logic [1:0]              ncons;
   logic                    stop;
   fdfe_addr_t              stop_tgt;
   logic [4:0]              nxt_off;
   logic                    blk_done;
   fdfe_addr_t              nxt_pc;
   fdfe_issue_s             lanes_d;
   logic [7:0]              sp_d;
   logic [BTB_W-1:0]        uidx;

   // ----------------------------------------------------------------
   // instruction cache
   // ----------------------------------------------------------------
   // raw bytes only
   // decoded state is never cached, so a redirect costs a full re-decode
   fdfe_imem #(
      .WIDTH (TAG_W + 128),
      .DEPTH (DEPTH)
   ) u_icache (
      .sys_clk_i (sys_clk_i),
      .en_i      (cm_en),
      .we_i      (cm_we),
      .addr_i    (cm_idx),
      .wdata_i   (cm_wdata),
      .rdata_o   (cm_rdata)
   );

   assign cm_we     = (st_q == F_MISS) && mem_rsp_i.ack;
   assign cm_en     = (st_q == F_REQ) || cm_we;
   assign cm_idx    = cm_we ? mem_req_q.addr[IDX_W+3:4] : fetch_pc_q[IDX_W+3:4];
   assign cm_wdata  = {mem_req_q.addr[31:IDX_W+4], mem_rsp_i.data};
   assign hit       = vld_q[fetch_pc_q[IDX_W+3:4]]
                      && (cm_rdata[TAG_W+127:128] == fetch_pc_q[31:IDX_W+4]);
   assign last_line = (ref_cnt_q == CNT_W'(PF_LINES - 1));
   assign adv       = (st_q == F_HOLD) && !redir_i.vld && (!issue_valid_q || issue_ready_i);

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         vld_q <= '0;
      end else if (cm_we) begin
         vld_q[cm_idx] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // fetch state
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         st_q       <= F_REQ;
         fetch_pc_q <= `FDFE_RESET_PC;
         base_q     <= '0;
         blk_q      <= '0;
         off_q      <= '0;
      end else if (redir_i.vld) begin
         fetch_pc_q <= {redir_i.pc[31:1], 1'b0};
         // an open refill must finish before the port is reused
         st_q       <= (st_q == F_MISS && !(cm_we && last_line)) ? F_MISS : F_REQ;
      end else begin
         case (st_q)
            F_REQ: begin
               st_q <= F_CHK;
            end
            F_CHK: begin
               if (hit) begin
                  blk_q  <= cm_rdata[127:0];
                  base_q <= {fetch_pc_q[31:4], 4'h0};
                  off_q  <= {1'b0, fetch_pc_q[3:1], 1'b0};
                  st_q   <= F_HOLD;
               end else begin
                  st_q <= F_MISS;
               end
            end
            F_HOLD: begin
               if (adv) begin
                  off_q <= nxt_off;
                  if (blk_done) begin
                     fetch_pc_q <= nxt_pc;
                     st_q       <= F_REQ;
                  end
               end
            end
            F_MISS: begin
               if (cm_we && last_line) begin
                  st_q <= F_REQ;
               end
            end
            default: begin
               st_q <= F_REQ;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // miss refill
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         mem_req_q <= '0;
         ref_cnt_q <= '0;
      end else if (st_q == F_CHK && !hit && !redir_i.vld) begin
         mem_req_q.vld  <= 1'b1;
         mem_req_q.addr <= {fetch_pc_q[31:4], 4'h0};
         ref_cnt_q      <= '0;
      end else if (cm_we) begin
         mem_req_q.addr <= mem_req_q.addr + `FDFE_BLK_STEP;
         ref_cnt_q      <= ref_cnt_q + CNT_W'(1);
         if (last_line) begin
            mem_req_q.vld <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // branch target buffer
   // ----------------------------------------------------------------
   assign uidx = btb_upd_i.pc[BTB_W:1];

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < BTB_ENTRIES; i++) begin
            btb_vld_q[i] <= 1'b0;
            btb_ctr_q[i] <= 2'h0;
            btb_tag_q[i] <= '0;
            btb_tgt_q[i] <= '0;
         end
      end else if (btb_upd_i.vld) begin
         if (btb_vld_q[uidx] && btb_tag_q[uidx] == btb_upd_i.pc) begin
            if (btb_upd_i.taken && btb_ctr_q[uidx] != 2'h3) begin
               btb_ctr_q[uidx] <= btb_ctr_q[uidx] + 2'h1;
            end else if (!btb_upd_i.taken && btb_ctr_q[uidx] != 2'h0) begin
               btb_ctr_q[uidx] <= btb_ctr_q[uidx] - 2'h1;
            end
            if (btb_upd_i.taken) begin
               btb_tgt_q[uidx] <= btb_upd_i.tgt;
            end
         end else if (btb_upd_i.taken) begin
            btb_vld_q[uidx] <= 1'b1;
            btb_tag_q[uidx] <= btb_upd_i.pc;
            btb_tgt_q[uidx] <= btb_upd_i.tgt;
            btb_ctr_q[uidx] <= `FDFE_BTB_CTR_INIT;
         end
      end
   end

   // ----------------------------------------------------------------
   // decode tables
   // ----------------------------------------------------------------
   function automatic fdfe_dec_s fdfe_decode(input logic [3:0] c);
      fdfe_dec_s d;
      d   = '0;
      d.n = 3'h1;
      case (c)
         `FDFE_CL_ALU: d.k[0] = UK_ALU;
         `FDFE_CL_LDOP: d.k[0] = UK_LDX;
         `FDFE_CL_STORE, `FDFE_CL_VSTORE: d.k[0] = UK_ST;
         `FDFE_CL_PUSH: begin
            d.k[0]   = UK_ST;
            d.sp_chg = `FDFE_SP_PUSH;
         end
         `FDFE_CL_POP: begin
            d.k[0]   = UK_LD;
            d.sp_chg = `FDFE_SP_POP;
         end
         `FDFE_CL_CALL, `FDFE_CL_RET: begin
            d.n          = 3'h2;
            d.first_only = 1'b1;
            d.k[0]       = (c == `FDFE_CL_CALL) ? UK_ST : UK_LD;
            d.k[1]       = UK_BR;
            d.sp_chg     = (c == `FDFE_CL_CALL) ? `FDFE_SP_PUSH : `FDFE_SP_POP;
         end
         `FDFE_CL_BRANCH: d.k[0] = UK_BR;
         `FDFE_CL_VLOAD: begin
            d.n          = 3'h2;
            d.first_only = 1'b1;
            d.k[0]       = UK_LD;
            d.k[1]       = UK_VEC;
         end
         `FDFE_CL_VSCAL: begin
            d.k[0]       = UK_VEC;
            d.first_only = !ENHANCED;
         end
         `FDFE_CL_VPACK: begin
            d.n          = ENHANCED ? `FDFE_PACK_ENH : `FDFE_PACK_BASE;
            d.first_only = !ENHANCED;
            d.k          = '{UK_VEC, UK_VEC, UK_VEC, UK_VEC};
         end
         `FDFE_CL_VSHUF: begin
            d.n          = 3'h2;
            d.first_only = 1'b1;
            d.k          = '{UK_VEC, UK_VEC, UK_VEC, UK_VEC};
         end
         default: begin
            d.n          = `FDFE_SLOT0_MAX;
            d.first_only = 1'b1;
         end
      endcase
      return d;
   endfunction : fdfe_decode

   // ----------------------------------------------------------------
   // slot extraction and steering
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0]      wd;
      logic [BTB_W-1:0] bi;
      wd = '0;
      bi = '0;
      for (int k = 0; k < 3; k++) begin
         pos[k]  = off_q + 5'(2 * k);
         pres[k] = pos[k] < `FDFE_BLK_END;
         wd      = blk_q[{pos[k][3:0], 3'h0} +: 16];
         cls[k]  = wd[3:0];
         imm[k]  = wd[15:8];
         spc[k]  = base_q + {27'h0, pos[k]};
         dec[k]  = fdfe_decode(cls[k]);
         bi      = spc[k][BTB_W:1];
         pred[k] = btb_vld_q[bi] && btb_tag_q[bi] == spc[k] && btb_ctr_q[bi][1];
         ptgt[k] = btb_tgt_q[bi];
      end
   end

   always_comb begin
      int lb;
      int nl;
      lb       = 0;
      nl       = 0;
      lanes_d  = '0;
      sp_d     = sp_q;
      stop     = 1'b0;
      stop_tgt = '0;
      take[0]  = pres[0];
      // later slots stop at the first main-only one (every multi-op but the enhanced packed op, plus the baseline VSCAL op)
      // stopping here defers it to next cycle's slot 0
      for (int k = 1; k < 3; k++) begin
         take[k] = take[k-1] && !pred[k-1] && pres[k] && !dec[k].first_only;
      end
      // slot order maps onto lane order
      for (int k = 0; k < 3; k++) begin
         lb = (k == 0) ? 0 : ((k == 1) ? `FDFE_LANE_SLOT1 : `FDFE_LANE_SLOT2);
         nl = (k == 0) ? 4 : 2;
         if (take[k]) begin
            for (int j = 0; j < nl; j++) begin
               if (3'(j) < dec[k].n) begin
                  lanes_d.lane[lb+j] = '{vld: 1'b1, kind: dec[k].k[j], sp_ofs: sp_d,
                                         imm: imm[k], pc: spc[k]};
               end
            end
            // running offset stands in for the pointer micro-op
            sp_d = sp_d + dec[k].sp_chg;
            if (pred[k]) begin
               stop     = 1'b1;
               stop_tgt = ptgt[k];
            end
         end
      end
   end

   assign ncons    = 2'(take[0]) + 2'(take[1]) + 2'(take[2]);
   assign nxt_off  = off_q + {2'h0, ncons, 1'b0};
   // leftover bytes come from the next block
   assign blk_done = stop || (nxt_off >= `FDFE_BLK_END);
   assign nxt_pc   = stop ? stop_tgt : base_q + `FDFE_BLK_STEP;

   // ----------------------------------------------------------------
   // issue register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         issue_valid_q <= 1'b0;
         issue_q       <= '0;
         sp_q          <= '0;
      end else if (redir_i.vld) begin
         // wrong-path micro-ops are dropped; the core resyncs the pointer
         issue_valid_q <= 1'b0;
         sp_q          <= '0;
      end else if (adv) begin
         issue_valid_q <= 1'b1;
         issue_q       <= lanes_d;
         sp_q          <= sp_d;
      end else if (issue_ready_i) begin
         issue_valid_q <= 1'b0;
      end
   end

   assign issue_valid_o = issue_valid_q;
   assign issue_o       = issue_q;
   assign mem_req_o     = mem_req_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   AST_REFILL_ALIGN: assert property (mem_req_q.vld |-> mem_req_q.addr[3:0] == 4'h0)
      else $error("refill address not block aligned");
   AST_BLOCK_ALIGN: assert property (st_q == F_CHK && hit && !redir_i.vld
      |=> st_q == F_HOLD && base_q[3:0] == 4'h0 && base_q[31:4] == $past(fetch_pc_q[31:4]))
      else $error("held block not the aligned fetch block");
   AST_REM14: assert property (adv && off_q == 5'h0E && !pred[0]
      |-> ncons == 2'h1 ##1 st_q == F_REQ && fetch_pc_q == $past(base_q) + `FDFE_BLK_STEP)
      else $error("offset 14 did not yield one instruction then next block");
   AST_SEQ_REFILL: assert property (cm_we && !last_line
      |=> mem_req_q.vld && mem_req_q.addr == $past(mem_req_q.addr) + `FDFE_BLK_STEP)
      else $error("refill not sequential");
   AST_MISS_START: assert property (st_q == F_CHK && !hit && !redir_i.vld
      |=> st_q == F_MISS && mem_req_q.vld && ref_cnt_q == '0)
      else $error("miss did not start refill");
   AST_FILL_VALID: assert property (cm_we |=> vld_q[$past(cm_idx)])
      else $error("filled line not marked valid");
   AST_SLOT0_LIMIT: assert property (take[0] |-> dec[0].n != 3'h0 && dec[0].n <= `FDFE_SLOT0_MAX)
      else $error("first decoder over four micro-ops");
   AST_SLOT_SINGLE: assert property (!ENHANCED && (take[1] || take[2])
      |-> (!take[1] || dec[1].n == 3'h1) && (!take[2] || dec[2].n == 3'h1))
      else $error("later decoder took a multi micro-op instruction");
   AST_IN_ORDER: assert property (adv
      |=> issue_valid_o && issue_o.lane[0].vld && issue_o.lane[0].pc == $past(spc[0]))
      else $error("issue group does not start at oldest instruction");
   AST_BTB_REDIRECT: assert property (adv && take[0] && pred[0]
      |=> st_q == F_REQ && fetch_pc_q == $past(ptgt[0]))
      else $error("predicted taken branch not followed");
   AST_PUSH_FOLD: assert property (take[0] && cls[0] == `FDFE_CL_PUSH
      |-> dec[0].n == 3'h1 && dec[0].sp_chg == `FDFE_SP_PUSH)
      else $error("push not folded");
   AST_STORE_FUSED: assert property (take[0] && (cls[0] == `FDFE_CL_STORE
      || cls[0] == `FDFE_CL_VSTORE) |-> dec[0].n == 3'h1 && dec[0].k[0] == UK_ST)
      else $error("store not fused");
   AST_LOAD_FUSED: assert property (take[0] && cls[0] == `FDFE_CL_LDOP
      |-> dec[0].n == 3'h1 && dec[0].k[0] == UK_LDX)
      else $error("load-op not fused");
   AST_VLOAD_SPLIT: assert property (take[0] && cls[0] == `FDFE_CL_VLOAD
      |-> dec[0].n == 3'h2 && dec[0].k[0] == UK_LD)
      else $error("vector load fused");
   AST_BASE_VSCAL: assert property (!ENHANCED && take[1] |-> cls[1] != `FDFE_CL_VSCAL)
      else $error("baseline vector op outside first decoder");
   AST_PACK_PAIR: assert property (ENHANCED && take[0] && cls[0] == `FDFE_CL_VPACK
      |-> dec[0].n == `FDFE_PACK_ENH)
      else $error("packed op not two micro-ops");
   AST_PACK_ANY: assert property (ENHANCED && take[0] && !pred[0] && pres[1]
      && cls[1] == `FDFE_CL_VPACK |-> take[1])
      else $error("packed op refused by second decoder");
   AST_SHUF_MAIN: assert property (take[1] || take[2]
      |-> (!take[1] || cls[1] != `FDFE_CL_VSHUF) && (!take[2] || cls[2] != `FDFE_CL_VSHUF))
      else $error("shuffle decoded outside first decoder");
   AST_DEFER: assert property (adv && !pred[0] && pres[1] && dec[1].first_only
      |-> ncons == 2'h1 ##1 (st_q == F_REQ || off_q == $past(pos[1])))
      else $error("main-only instruction not deferred to slot 0");
endmodule : fdfe_front_end

// File: src/fdfe_imem.sv
// single-port block memory with registered read data
`timescale 1ns/1ps
module fdfe_imem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                     sys_clk_i,
   input  wire logic                     en_i,
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] addr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge sys_clk_i) begin
      if (en_i && we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
      if (en_i && !we_i) begin
         rdata_o <= mem_q[addr_i];
      end
   end
endmodule : fdfe_imem

// File: tb/fdfe_front_end_tb.sv
// self-checking bench for the fetch/decode front end
`timescale 1ns/1ps
module fdfe_front_end_tb;
   import fdfe_pkg::*;
   logic          sys_clk_i     = 1'b0;
   logic          resetn_i      = 1'b0;
   logic          issue_ready_i = 1'b1;
   logic          issue_valid_o;
   fdfe_redir_s   redir_i       = '0;
   fdfe_btb_upd_s btb_upd_i     = '0;
   fdfe_memreq_s  mem_req_o;
   fdfe_memrsp_s  mem_rsp_i;
   fdfe_issue_s   issue_o;
   fdfe_issue_s   g;
   logic          issue_valid_e;
   fdfe_memreq_s  mem_req_e;
   fdfe_memrsp_s  mem_rsp_e;
   fdfe_issue_s   issue_e;
   int            n_fail        = 0;
   int            total_checks  = 0;
   int            n_ack         = 0;
   fdfe_addr_t    last_ack      = '0;
   fdfe_front_end #(.ICACHE_BYTES(1024), .BTB_ENTRIES(4), .PF_LINES(2)) fdfe_front_end_i (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .redir_i(redir_i),
      .btb_upd_i(btb_upd_i), .mem_rsp_i(mem_rsp_i), .mem_req_o(mem_req_o),
      .issue_ready_i(issue_ready_i), .issue_valid_o(issue_valid_o), .issue_o(issue_o));
   fdfe_mem_model fdfe_mem_model_i (
      .sys_clk_i(sys_clk_i), .mem_req_i(mem_req_o), .mem_rsp_o(mem_rsp_i));
   // enhanced variant, fed from its own memory image
   fdfe_front_end #(.ENHANCED(1'b1), .ICACHE_BYTES(1024), .BTB_ENTRIES(4), .PF_LINES(2))
      fdfe_front_end_enh_i (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .redir_i(redir_i),
      .btb_upd_i(btb_upd_i), .mem_rsp_i(mem_rsp_e), .mem_req_o(mem_req_e),
      .issue_ready_i(issue_ready_i), .issue_valid_o(issue_valid_e), .issue_o(issue_e));
   fdfe_mem_model fdfe_mem_model_enh_i (
      .sys_clk_i(sys_clk_i), .mem_req_i(mem_req_e), .mem_rsp_o(mem_rsp_e));
   initial forever #25 sys_clk_i = ~sys_clk_i;
   // ----------------------------------------
   // compare and transfer tasks
   // ----------------------------------------
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_val
   task automatic chk_lane(input int l, input logic v, input fdfe_kind_e k, input fdfe_addr_t pc);
      chk_val(32'(g.lane[l].vld), 32'(v), "lane valid");
      if (v) begin
         chk_val(32'(g.lane[l].kind), 32'(k), "lane kind");
         chk_val(g.lane[l].pc, pc, "lane pc");
      end
   endtask : chk_lane
   task automatic grab();
      for (int i = 0; i < 400 && issue_valid_o !== 1'b1; i++) @(negedge sys_clk_i);
      chk_val(32'(issue_valid_o), 32'h1, "group wait");
      g = issue_o;
      @(negedge sys_clk_i);
   endtask : grab
   task automatic jump(input fdfe_addr_t pc);
      redir_i.pc = pc;
      redir_i.vld = 1'b1;
      @(negedge sys_clk_i);
      redir_i.vld = 1'b0;
      chk_val(32'(issue_valid_o), 32'h0, "flush");
   endtask : jump
   // refill pairs must step up one aligned block at a time
   always @(posedge sys_clk_i) begin
      if (resetn_i && mem_req_o.vld && mem_rsp_i.ack) begin
         chk_val(32'(mem_req_o.addr[3:0]), 32'h0, "block align");
         if (n_ack % 2 == 1) chk_val(mem_req_o.addr, last_ack + 32'h10, "refill order");
         n_ack <= n_ack + 1;
         last_ack <= mem_req_o.addr;
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_enh();
      issue_ready_i = 1'b0;
      for (int i = 0; i < 400 && issue_valid_e !== 1'b1; i++) @(negedge sys_clk_i);
      chk_val(32'(issue_valid_e), 32'h1, "enhanced group wait");
      g = issue_e;
      chk_lane(1, 1, UK_VEC, 32'h0);
      chk_lane(2, 0, UK_ALU, 32'h0);
      chk_lane(5, 1, UK_VEC, 32'h2);
      chk_lane(6, 1, UK_ALU, 32'h4);
   endtask : t_enh
   task automatic t_stream();
      issue_ready_i = 1'b0;
      grab();
      chk_val(issue_o.lane[0].pc, g.lane[0].pc, "stall hold");
      issue_ready_i = 1'b1;
      chk_lane(0, 1, UK_ALU, 32'h0);
      chk_lane(1, 0, UK_ALU, 32'h0);
      chk_lane(4, 1, UK_ALU, 32'h2);
      chk_lane(6, 1, UK_ALU, 32'h4);
   endtask : t_stream
   task automatic t_stack();
      jump(32'h40);
      grab();
      chk_lane(0, 1, UK_ST, 32'h40);
      chk_lane(1, 0, UK_ALU, 32'h0);
      chk_lane(6, 1, UK_LD, 32'h44);
      chk_val(32'(g.lane[4].sp_ofs), 32'hFC, "push offset");
      chk_val(32'(g.lane[6].sp_ofs), 32'hFC, "pop offset");
   endtask : t_stack
   task automatic t_steer();
      jump(32'h50);
      grab();
      chk_lane(4, 0, UK_ALU, 32'h0);
      grab();
      for (int l = 0; l < 4; l++) chk_lane(l, 1, UK_VEC, 32'h52);
      chk_lane(4, 0, UK_ALU, 32'h0);
      grab();
      chk_lane(0, 1, UK_VEC, 32'h54);
   endtask : t_steer
   task automatic t_loads();
      jump(32'h60);
      grab();
      chk_lane(0, 1, UK_LDX, 32'h60);
      grab();
      chk_lane(0, 1, UK_LD, 32'h62);
      chk_lane(1, 1, UK_VEC, 32'h62);
   endtask : t_loads
   task automatic t_odd();
      fdfe_mem_model_i.dly = 3;
      jump(32'h7E);
      grab();
      chk_lane(0, 1, UK_ALU, 32'h7E);
      chk_lane(4, 0, UK_ALU, 32'h0);
      grab();
      chk_lane(0, 1, UK_ALU, 32'h80);
   endtask : t_odd
   task automatic t_btb();
      btb_upd_i = '{vld: 1'b1, taken: 1'b1, pc: 32'h90, tgt: 32'h40};
      @(negedge sys_clk_i);
      btb_upd_i.vld = 1'b0;
      jump(32'h90);
      grab();
      chk_lane(0, 1, UK_BR, 32'h90);
      chk_lane(4, 0, UK_ALU, 32'h0);
      grab();
      chk_lane(0, 1, UK_ST, 32'h40);
   endtask : t_btb
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (3) @(negedge sys_clk_i);
      fdfe_mem_model_i.img[8'h40] = 8'h04;
      fdfe_mem_model_i.img[8'h44] = 8'h05;
      fdfe_mem_model_i.img[8'h52] = 8'h0B;
      fdfe_mem_model_i.img[8'h54] = 8'h0A;
      fdfe_mem_model_i.img[8'h60] = 8'h01;
      fdfe_mem_model_i.img[8'h62] = 8'h09;
      fdfe_mem_model_i.img[8'h90] = 8'h08;
      fdfe_mem_model_enh_i.img[8'h00] = 8'h0B;
      fdfe_mem_model_enh_i.img[8'h02] = 8'h0B;
      resetn_i = 1'b1;
      t_enh();
      t_stream();
      t_stack();
      t_steer();
      t_loads();
      t_odd();
      t_btb();
      stop_test();
   end
   initial begin
      #250000;
      n_fail++;
      stop_test();
   end
endmodule : fdfe_front_end_tb

// File: tb/fdfe_mem_model.sv
// refill memory model standing behind the front end
`timescale 1ns/1ps
module fdfe_mem_model (
   input  wire logic                   sys_clk_i,
   input  wire fdfe_pkg::fdfe_memreq_s mem_req_i,
   output fdfe_pkg::fdfe_memrsp_s      mem_rsp_o
);
   import fdfe_pkg::*;
   logic [7:0] img [0:255];
   int         dly = 0;
   int         cnt = 0;
   initial begin
      foreach (img[i]) img[i] = 8'h00;
      mem_rsp_o = '0;
   end
   // data toggles between acks so a late sample never looks valid
   always @(negedge sys_clk_i) begin
      mem_rsp_o.ack <= mem_req_i.vld && cnt >= dly;
      if (mem_req_i.vld && cnt >= dly) begin
         cnt <= 0;
         for (int b = 0; b < 16; b++) begin
            mem_rsp_o.data[8*b +: 8] <= img[8'(mem_req_i.addr[7:0] + 8'(b))];
         end
      end else begin
         mem_rsp_o.data <= ~mem_rsp_o.data;
         if (mem_req_i.vld) cnt <= cnt + 1;
      end
   end
endmodule : fdfe_mem_model
